/* low_battery_detect_consts.vh */
// constants for the low-battery detect register bank
`ifndef LOW_BATTERY_DETECT_CONSTS_VH
`define LOW_BATTERY_DETECT_CONSTS_VH

// ==========================================
// register offsets
`define OFF_LOW_BATTERY_CONTROL      5'h05
`define OFF_LOW_BATTERY_STATUS_ROUTE 5'h06
`define OFF_PAGE_SELECT_REGISTER     5'h1f
`define OFF_IRQ_STATUS               5'h07
`define OFF_IRQ_MASK                 5'h08

// ==========================================
// reset values
`define RST_LOW_BATTERY_CONTROL      8'hb1
`define RST_LOW_BATTERY_STATUS_ROUTE 8'h96
`define RST_PAGE_SELECT_REGISTER     8'h00
`define RST_IRQ_MASK                 2'h0

// ==========================================
// field positions
`define BIT_MONITOR_ON     3
`define BIT_ABOVE_FLAG     7
`define BIT_PIN_ROUTE      6
`define PAGE_HI            1
`define PAGE_LO            0
`define PAGE_ZERO          2'h0
`define PAGE_ONE           2'h1
`define IRQ_BIT_FALL       0
`define IRQ_BIT_RISE       1

`endif

/* low_battery_detect_regs.v */
// register bank for the supply low-battery detector
`timescale 1ns/100ps
// ==========================================
// Overview of operation
// - control bit 3 turns the supply monitor on or off
// - control bits 2..0 pick one of eight ascending trip levels
// - status bit 7 is read-only, 1 when the monitor is on and supply above trip level
// - status bit 6 routes the detect result to the output pin
// - low-battery registers at 0x05 and 0x06 decode only in page 1
// - page select register decodes at 0x1f in every page
// - page select bits 1..0 choose the presented register page
// - page code 00 is page 0, 01 is page 1, others unused
`include "low_battery_detect_consts.vh"

module low_battery_detect_regs #(
  parameter ADDR_WIDTH = 5,
  parameter DATA_WIDTH = 8
) (
  input  wire                  clock,
  input  wire                  rst,
  input  wire [ADDR_WIDTH-1:0] addr,
  input  wire [DATA_WIDTH-1:0] wr_data,
  input  wire                  wr_strobe,
  input  wire                  rd_strobe,
  output reg  [DATA_WIDTH-1:0] rd_data,
  input  wire                  comparator_above,
  output wire                  battery_monitor_on,
  output wire [2:0]            battery_trip_level,
  output reg                   battery_flag_pin,
  output wire                  irq
);

  // ==========================================
  // writable bit masks
  localparam [7:0] PAGE_WRITABLE = 8'hff; // all bits stored, 1..0 decode
  localparam [7:0] CTRL_WRITABLE = 8'hff; // upper nibble kept by software
  localparam [7:0] STAT_WRITABLE = 8'h7f; // bit 7 is the live flag
  localparam [1:0] MASK_WRITABLE = 2'h3;

  // ==========================================
  // register storage
  // configuration bytes
  reg [7:0]            low_battery_control;
  reg [7:0]            low_battery_status_route;
  reg [7:0]            page_select_register;

  // event status and mask
  reg [1:0]            irq_status;
  reg [1:0]            irq_mask;

  // detect path
  reg                  supply_above_level_flag;
  reg                  prev_flag;

  // next values of the configuration bytes
  reg [7:0]            next_low_battery_control;
  reg [7:0]            next_low_battery_status_route;
  reg [7:0]            next_page_select_register;

  // next values of events and mask
  reg [1:0]            next_irq_status;
  reg [1:0]            next_irq_mask;

  // next values of the detect path and read port
  reg                  next_supply_above_level_flag;
  reg                  next_prev_flag;
  reg                  next_battery_flag_pin;
  reg [7:0]            read_view;
  reg [DATA_WIDTH-1:0] next_rd_data;

  // ==========================================
  // decode nets
  // page field
  wire [1:0]           cur_page;
  wire                 page_one;

  // register selects
  wire                 sel_page;
  wire                 sel_ctrl;
  wire                 sel_stat;
  wire                 sel_irqs;
  wire                 sel_mask;

  // qualified strobes
  wire                 wr_page;
  wire                 wr_ctrl;
  wire                 wr_stat;
  wire                 wr_mask;
  wire                 irq_read;

  // detect path and events
  wire                 battery_flag_pin_route;
  wire [1:0]           events;
  wire [1:0]           irq_pending;
  wire [7:0]           status_view;

  // ==========================================
  // helper functions
  // address match, optionally gated by page 1
  function hit;
    input [ADDR_WIDTH-1:0] a;
    input [ADDR_WIDTH-1:0] off;
    input                  need_page1;
    input                  in_page1;
    begin
      hit = (a == off) && (!need_page1 || in_page1);
    end
  endfunction

  // two event bits widened to a register byte
  function [7:0] pad_events;
    input [1:0] bits;
    begin
      pad_events = {6'h00, bits};
    end
  endfunction

  // keep read-only bits, take writable bits from the bus
  function [7:0] merge_writable;
    input [7:0] old_value;
    input [7:0] bus_value;
    input [7:0] writable;
    begin
      merge_writable = (old_value & ~writable) | (bus_value & writable);
    end
  endfunction

  // ==========================================
  // decoding
  // page field and page-one test
  assign cur_page = page_select_register[`PAGE_HI:`PAGE_LO];
  assign page_one = (cur_page == `PAGE_ONE);

  // selects; 0x05 and 0x06 vanish outside page 1
  assign sel_page = hit(addr, `OFF_PAGE_SELECT_REGISTER, 1'b0, page_one);
  assign sel_ctrl = hit(addr, `OFF_LOW_BATTERY_CONTROL, 1'b1, page_one);
  assign sel_stat = hit(addr, `OFF_LOW_BATTERY_STATUS_ROUTE, 1'b1, page_one);
  assign sel_irqs = hit(addr, `OFF_IRQ_STATUS, 1'b0, page_one);
  assign sel_mask = hit(addr, `OFF_IRQ_MASK, 1'b0, page_one);

  // strobes qualified by selects
  assign wr_page  = wr_strobe & sel_page;
  assign wr_ctrl  = wr_strobe & sel_ctrl;
  assign wr_stat  = wr_strobe & sel_stat;
  assign wr_mask  = wr_strobe & sel_mask;
  assign irq_read = rd_strobe & sel_irqs;

  // control fields out to the analog side
  assign battery_monitor_on     = low_battery_control[`BIT_MONITOR_ON];
  assign battery_trip_level     = low_battery_control[2:0];
  assign battery_flag_pin_route = low_battery_status_route[`BIT_PIN_ROUTE];

  // flag edges: bit 1 rose, bit 0 fell
  assign events = {supply_above_level_flag & ~prev_flag,
                   ~supply_above_level_flag & prev_flag};

  // status byte as read: live flag over the route bits
  assign status_view = {supply_above_level_flag, low_battery_status_route[6:0]};

  // level interrupt from unmasked sticky events
  assign irq_pending = irq_status & irq_mask;
  assign irq         = |irq_pending;

  // ==========================================
  // next-value logic
  // page select
  always @* begin
    next_page_select_register = page_select_register;
    if (wr_page) begin
      next_page_select_register = merge_writable(page_select_register,
                                                 wr_data[7:0], PAGE_WRITABLE);
    end
  end

  // control byte, upper nibble kept by software
  always @* begin
    next_low_battery_control = low_battery_control;
    if (wr_ctrl) begin
      next_low_battery_control = merge_writable(low_battery_control,
                                                wr_data[7:0], CTRL_WRITABLE);
    end
  end

  // status and route byte, bit 7 read-only
  always @* begin
    next_low_battery_status_route = low_battery_status_route;
    if (wr_stat) begin
      next_low_battery_status_route = merge_writable(low_battery_status_route,
                                                     wr_data[7:0], STAT_WRITABLE);
    end
  end

  // event mask
  always @* begin
    next_irq_mask = irq_mask;
    if (wr_mask) begin
      next_irq_mask = wr_data[1:0] & MASK_WRITABLE;
    end
  end

  // sticky events, read clears, a new event wins
  always @* begin
    if (irq_read) begin
      next_irq_status = events;
    end else begin
      next_irq_status = irq_status | events;
    end
  end

  // detect flag, held low while the monitor is off
  always @* begin
    next_supply_above_level_flag = battery_monitor_on & comparator_above;
  end

  // flag history for edge detection
  always @* begin
    next_prev_flag = supply_above_level_flag;
  end

  // routed pin follows the live flag
  always @* begin
    next_battery_flag_pin = battery_flag_pin_route & supply_above_level_flag;
  end

  // byte presented by the selected register
  always @* begin
    read_view = 8'h00;
    case (1'b1)
      sel_page: begin
        read_view = page_select_register;
      end
      sel_ctrl: begin
        read_view = low_battery_control;
      end
      sel_stat: begin
        read_view = status_view;
      end
      sel_irqs: begin
        read_view = pad_events(irq_status);
      end
      sel_mask: begin
        read_view = pad_events(irq_mask);
      end
      default: begin
        read_view = 8'h00; // unmapped reads zero
      end
    endcase
  end

  // read port, zero unless a read was strobed
  always @* begin
    next_rd_data = {DATA_WIDTH{1'b0}};
    if (rd_strobe) begin
      next_rd_data = read_view;
    end
  end

  // ==========================================
  // configuration registers
  // page select
  always @(posedge clock) begin
    if (rst) begin
      page_select_register <= `RST_PAGE_SELECT_REGISTER;
    end else begin
      page_select_register <= next_page_select_register;
    end
  end

  // control byte
  always @(posedge clock) begin
    if (rst) begin
      low_battery_control <= `RST_LOW_BATTERY_CONTROL;
    end else begin
      low_battery_control <= next_low_battery_control;
    end
  end

  // status and route byte
  always @(posedge clock) begin
    if (rst) begin
      low_battery_status_route <= `RST_LOW_BATTERY_STATUS_ROUTE;
    end else begin
      low_battery_status_route <= next_low_battery_status_route;
    end
  end

  // event mask
  always @(posedge clock) begin
    if (rst) begin
      irq_mask <= `RST_IRQ_MASK;
    end else begin
      irq_mask <= next_irq_mask;
    end
  end

  // ==========================================
  // detect path and read port
  // sticky events
  always @(posedge clock) begin
    if (rst) begin
      irq_status <= 2'h0;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  // detect flag
  always @(posedge clock) begin
    if (rst) begin
      supply_above_level_flag <= 1'b0;
    end else begin
      supply_above_level_flag <= next_supply_above_level_flag;
    end
  end

  // flag history
  always @(posedge clock) begin
    if (rst) begin
      prev_flag <= 1'b0;
    end else begin
      prev_flag <= next_prev_flag;
    end
  end

  // routed pin
  always @(posedge clock) begin
    if (rst) begin
      battery_flag_pin <= 1'b0;
    end else begin
      battery_flag_pin <= next_battery_flag_pin;
    end
  end

  // read data, valid the cycle after the strobe
  always @(posedge clock) begin
    if (rst) begin
      rd_data <= {DATA_WIDTH{1'b0}};
    end else begin
      rd_data <= next_rd_data;
    end
  end

endmodule

/* low_battery_detect_regs_assertions.sv */
// assertion checker for the low-battery register bank
`timescale 1ns/100ps
// ========
// port checks
module lbd_chk (input logic clock, rst, wr_strobe, rd_strobe, comparator_above, irq,
  input logic [4:0] addr,
  input logic [7:0] wr_data, rd_data,
  input logic [2:0] battery_trip_level,
  input logic       battery_monitor_on, battery_flag_pin);
  // page field shadow and decoded accesses
  logic [1:0] pg;
  wire        w5 = wr_strobe && addr == 5'h05 && pg == 2'h1;
  wire        r6 = rd_strobe && addr == 5'h06 && pg == 2'h1;
  always_ff @(posedge clock)
    if (rst)
      pg <= 2'h0;
    else if (wr_strobe && addr == 5'h1f)
      pg <= wr_data[1:0];
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  chk_read_idle_zero: assert property (!$past(rd_strobe) |-> rd_data == 8'h00)
    else $error("idle");
  chk_control_write: assert property (w5 |=>
    {battery_monitor_on, battery_trip_level} == $past(wr_data[3:0])) else $error("ctrl");
  chk_control_hold: assert property ($changed(battery_trip_level) |-> $past(w5))
    else $error("hold");
  chk_page_gate: assert property (rd_strobe && addr inside {5'h05, 5'h06} && pg != 2'h1
    |=> rd_data == 8'h00) else $error("gate");
  chk_page_readback: assert property (rd_strobe && addr == 5'h1f
    |=> rd_data[1:0] == $past(pg)) else $error("page");
  chk_status_flag: assert property (battery_monitor_on[*2] ##0
    (r6 && $stable(comparator_above)) |=> rd_data[7] == $past(comparator_above))
    else $error("flag");
  chk_pin_monitor_off: assert property ((!battery_monitor_on)[*3] |-> !battery_flag_pin)
    else $error("off");
  chk_pin_below_level: assert property ((!comparator_above)[*3] |-> !battery_flag_pin)
    else $error("below");
  cover property (r6);
  cover property (battery_flag_pin);
  cover property (irq);
endmodule
bind low_battery_detect_regs lbd_chk u_chk (.clock(clock), .rst(rst), .wr_strobe(wr_strobe),
  .rd_strobe(rd_strobe), .comparator_above(comparator_above), .irq(irq), .addr(addr),
  .wr_data(wr_data), .rd_data(rd_data), .battery_trip_level(battery_trip_level),
  .battery_monitor_on(battery_monitor_on), .battery_flag_pin(battery_flag_pin));

/* tb_top.sv */
// self-checking bench for the low-battery register bank
`timescale 1ns/100ps
// ========
// bench top
module tb_top;
  logic       clock, rst, wr_strobe, rd_strobe, comparator_above;
  logic [4:0] addr;
  logic [7:0] wr_data;
  wire  [7:0] rd_data;
  wire  [2:0] battery_trip_level;
  wire        battery_monitor_on, battery_flag_pin, irq;
  int         num_errors, tests_run, cyc;
  low_battery_detect_regs DUT (.clock(clock), .rst(rst), .addr(addr), .wr_data(wr_data),
    .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data), .irq(irq),
    .comparator_above(comparator_above), .battery_monitor_on(battery_monitor_on),
    .battery_trip_level(battery_trip_level), .battery_flag_pin(battery_flag_pin));
  // compare and count
  task chk(input logic [7:0] s, e);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("Error %0t: got %h want %h", $time, s, e);
    end
  endtask
  // one access; a read compares with d
  task acc(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wr_data <= d;
    wr_strobe <= w;
    rd_strobe <= !w;
    @(posedge clock);
    wr_strobe <= 1'b0;
    rd_strobe <= 1'b0;
    #1;
    if (!w) chk(rd_data, d);
  endtask
  // page-1 access framed by page selects
  task pacc(input logic w, input logic [4:0] a, input logic [7:0] d);
    acc(1, 5'h1f, 8'h01);
    acc(w, a, d);
    acc(1, 5'h1f, 8'h00);
  endtask
  // counts and verdict
  task test_done;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // clock
  initial begin
    clock = 0;
    forever #4 clock = ~clock;
  end
  // hang guard
  always @(posedge clock) begin
    cyc++;
    if (cyc == 2000) begin
      num_errors++;
      test_done;
    end
  end
  // main sequence
  initial begin
    {wr_strobe, rd_strobe, comparator_above, addr, wr_data} = 0;
    rst = 1;
    repeat (2) @(posedge clock);
    rst <= 0;
    pacc(0, 5'h05, 8'hb1);
    pacc(0, 5'h06, 8'h16);
    for (int i = 0; i < 8; i++) begin
      pacc(1, 5'h05, 8'hb8 | i[7:0]);
      chk({4'h0, battery_monitor_on, battery_trip_level}, 8'h08 | i[7:0]);
    end
    acc(0, 5'h07, 8'h00);
    acc(1, 5'h08, 8'h02);
    comparator_above <= 1;
    repeat (3) @(posedge clock);
    #1 chk(irq, 8'h01);
    pacc(0, 5'h06, 8'h96);
    chk(battery_flag_pin, 8'h00);
    acc(0, 5'h07, 8'h02);
    chk(irq, 8'h00);
    pacc(1, 5'h06, 8'h56);
    pacc(0, 5'h06, 8'hd6);
    chk(battery_flag_pin, 8'h01);
    comparator_above <= 0;
    repeat (3) @(posedge clock);
    #1 chk(battery_flag_pin, 8'h00);
    chk(irq, 8'h00);
    acc(0, 5'h07, 8'h01);
    pacc(1, 5'h05, 8'hb0);
    chk(battery_monitor_on, 8'h00);
    acc(0, 5'h05, 8'h00);
    acc(1, 5'h05, 8'hbf);
    acc(1, 5'h1f, 8'h02);
    acc(0, 5'h06, 8'h00);
    acc(0, 5'h1f, 8'h02);
    acc(0, 5'h10, 8'h00);
    acc(1, 5'h1f, 8'h00);
    pacc(0, 5'h05, 8'hb0);
    test_done;
  end
endmodule
